// ---- rcm_seq.sv ----
// Cooling, soft dry and automatic mode sequencer with APB registers
`timescale 1ns/1ps
`include "rcm_defs.svh"
// Functional notes
// - User setpoint accepted only between 16 and 30 degrees, compared with intake.
// - Cooling stops compressor at setpoint, restarts it when cooling is demanded again.
// - After any stop the compressor stays off at least 3 minutes.
// - Every compressor start runs at least 60 seconds whatever the temperature, unless an off command stops it.
// - After a cooling restart's forced run a 7 minute time-save interval applies.
// - Soft dry sequence begins once intake reaches the setpoint.
// - First soft dry on lasts at most 10 minutes, then off 6 unless the dry off fallback to cooling comes first.
// - Afterwards soft dry cycles on and off by intake versus setpoint.
// - In dry off, after 3 minutes compressor off, go cooling above cooling on point.
// - Automatic mode runs indoor fan at lowest speed 25 seconds before judging.
// - Automatic mode keeps its chosen mode until an off command or the dry off fallback to cooling.
// - Automatic standard setpoints are 25 for cooling and 22 for soft dry.
// - Up and down shift the automatic setpoint one level, plus or minus 2.
// - Open strap raises judge threshold and standard setpoints by 2 degrees.
// - Outdoor fan switches on and off together with the compressor.
module rcm_seq #(
  parameter int unsigned TICK_CYCLES = `RCM_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] intake_temp,
  input wire logic mode_offset_strap,
  output logic comp_on,
  output logic outdoor_fan_on,
  output logic [2:0] indoor_fan_speed
);
  logic tick;
  logic run_load, off_load, ph_load, run_done, off_done, ph_done;
  logic [9:0] ph_val;
  logic [7:0] temp_m_q, temp_q, strap_add, std_sp, eff_sp, judge_thr, cool_on_pt;
  logic strap_m_q, strap_q, cool_dem, tsave, req;
  rcm_pkg::rcm_state_e state_q, state_d;
  rcm_pkg::rcm_ctrl_s ctrl_q, ctrl_d;
  rcm_pkg::rcm_cmd_s cmd;
  rcm_pkg::rcm_fan_e fan_q, fan_d;
  logic [7:0] user_sp_q, user_sp_d;
  logic [1:0] level_q, level_d;
  logic auto_q, auto_d, cool_sel_q, cool_sel_d;
  logic restart_q, restart_d, comp_q, comp_d, ofan_q;
  logic [31:0] prdata_q, prdata_d, rd_val;
  logic pready_q, pslverr_q, pslverr_d, rd_err, apb_setup, apb_wr;

  rcm_tick #(.CYCLES(TICK_CYCLES)) u_tick (.clk(clk), .reset(reset), .tick(tick));
  rcm_timer u_run (.clk(clk), .reset(reset), .tick(tick), .load(run_load),
    .load_val(10'(`RCM_FORCED_TK)), .done(run_done));
  rcm_timer u_off (.clk(clk), .reset(reset), .tick(tick), .load(off_load),
    .load_val(10'(`RCM_RESTART_TK)), .done(off_done));
  rcm_timer u_phase (.clk(clk), .reset(reset), .tick(tick), .load(ph_load),
    .load_val(ph_val), .done(ph_done));

  // Sensor word changes slowly, so a plain two-stage sync is enough
  always_ff @(posedge clk) begin
    if (reset) begin
      temp_m_q <= 8'h00;
      temp_q <= 8'h00;
      strap_m_q <= 1'b0;
      strap_q <= 1'b0;
    end else begin
      temp_m_q <= intake_temp;
      temp_q <= temp_m_q;
      strap_m_q <= mode_offset_strap;
      strap_q <= strap_m_q;
    end
  end

  always_comb begin
    strap_add = strap_q ? `RCM_STRAP_ADD : 8'h00;
    std_sp = (cool_sel_q ? `RCM_AUTO_COOL_SP : `RCM_AUTO_DRY_SP) + strap_add;
    judge_thr = `RCM_JUDGE_THR + strap_add;
    if (!auto_q) begin
      eff_sp = user_sp_q;
    end else if (level_q == `RCM_LVL_UP) begin
      eff_sp = std_sp + `RCM_LVL_STEP;
    end else if (level_q == `RCM_LVL_DN) begin
      eff_sp = std_sp - `RCM_LVL_STEP;
    end else begin
      eff_sp = std_sp;
    end
    cool_on_pt = eff_sp + `RCM_COOL_ON_HYST;
    cool_dem = temp_q > eff_sp;
  end

  assign apb_setup = psel & ~penable & ~pready_q;
  assign apb_wr = psel & penable & pready_q & pwrite;
  // Read data is captured in the setup cycle, one cycle before the access edge
  always_comb begin
    rd_val = 32'h0;
    rd_err = 1'b0;
    if (paddr == `RCM_OFF_CTRL) begin
      rd_val = {28'h0, ctrl_q};
    end else if (paddr == `RCM_OFF_SETPT) begin
      rd_val = {24'h0, user_sp_q};
    end else if (paddr == `RCM_OFF_STATUS) begin
      rd_val = {15'h0, strap_q, eff_sp, level_q, cool_sel_q, auto_q, comp_q, state_q};
    end else if (paddr == `RCM_OFF_TEMP) begin
      rd_val = {24'h0, temp_q};
    end else if (paddr != `RCM_OFF_CMD) begin
      rd_err = 1'b1;
    end
    prdata_d = apb_setup ? rd_val : prdata_q;
    pslverr_d = apb_setup & rd_err;
    cmd = '0;
    if (apb_wr && paddr == `RCM_OFF_CMD) begin
      cmd = rcm_pkg::rcm_cmd_s'(pwdata[3:0]);
    end
  end

  always_comb begin
    case (state_q)
      rcm_pkg::ST_COOL, rcm_pkg::ST_DRY_WAIT, rcm_pkg::ST_DRY_CYC: req = cool_dem;
      rcm_pkg::ST_DRY_ON: req = 1'b1;
      default: req = 1'b0;
    endcase
    tsave = (state_q == rcm_pkg::ST_COOL) && restart_q && !ph_done;
    comp_d = comp_q;
    if (state_q == rcm_pkg::ST_OFF) begin
      comp_d = 1'b0;
    end else if (comp_q) begin
      if (!req && run_done && !tsave) begin
        comp_d = 1'b0;
      end
    end else if (req && off_done) begin
      comp_d = 1'b1;
    end
    run_load = comp_d & ~comp_q;
    off_load = comp_q & ~comp_d;
    if (state_q == rcm_pkg::ST_OFF) begin
      fan_d = rcm_pkg::FAN_STOP;
    end else if (state_q == rcm_pkg::ST_JUDGE) begin
      fan_d = rcm_pkg::LOWEST_FAN_SPEED;
    end else begin
      case (ctrl_q.fan_sel)
        rcm_pkg::FSEL_LO: fan_d = rcm_pkg::FAN_LO;
        rcm_pkg::FSEL_ME: fan_d = rcm_pkg::FAN_ME;
        rcm_pkg::FSEL_HI: fan_d = rcm_pkg::FAN_HI;
        default: fan_d = comp_q ? rcm_pkg::FAN_ME : rcm_pkg::LOWEST_FAN_SPEED;
      endcase
    end
  end

  always_comb begin
    state_d = state_q;
    ctrl_d = ctrl_q;
    user_sp_d = user_sp_q;
    level_d = level_q;
    auto_d = auto_q;
    cool_sel_d = cool_sel_q;
    restart_d = restart_q | run_load;
    ph_load = 1'b0;
    ph_val = 10'h000;
    if (apb_wr && paddr == `RCM_OFF_CTRL) begin
      ctrl_d = rcm_pkg::rcm_ctrl_s'(pwdata[3:0]);
    end
    if (apb_wr && paddr == `RCM_OFF_SETPT && pwdata[7:0] >= `RCM_SP_MIN &&
        pwdata[7:0] <= `RCM_SP_MAX) begin
      user_sp_d = pwdata[7:0];
    end
    if (cmd.up) begin
      if (auto_q) begin
        level_d = (level_q == `RCM_LVL_DN) ? `RCM_LVL_STD : `RCM_LVL_UP;
      end else if (user_sp_q < `RCM_SP_MAX) begin
        user_sp_d = user_sp_q + 8'h01;
      end
    end else if (cmd.down) begin
      if (auto_q) begin
        level_d = (level_q == `RCM_LVL_UP) ? `RCM_LVL_STD : `RCM_LVL_DN;
      end else if (user_sp_q > `RCM_SP_MIN) begin
        user_sp_d = user_sp_q - 8'h01;
      end
    end
    case (state_q)
      rcm_pkg::ST_OFF: begin
        if (cmd.start) begin
          level_d = `RCM_LVL_STD;
          restart_d = 1'b0;
          auto_d = (ctrl_q.mode == rcm_pkg::MODE_AUTO);
          cool_sel_d = (ctrl_q.mode != rcm_pkg::MODE_DRY);
          if (ctrl_q.mode == rcm_pkg::MODE_AUTO) begin
            state_d = rcm_pkg::ST_JUDGE;
            ph_load = 1'b1;
            ph_val = 10'(`RCM_JUDGE_TK);
          end else if (ctrl_q.mode == rcm_pkg::MODE_DRY) begin
            state_d = rcm_pkg::ST_DRY_WAIT;
          end else begin
            state_d = rcm_pkg::ST_COOL;
          end
        end
      end
      rcm_pkg::ST_JUDGE: begin
        if (ph_done) begin
          if (temp_q >= judge_thr) begin
            state_d = rcm_pkg::ST_COOL;
            cool_sel_d = 1'b1;
          end else begin
            state_d = rcm_pkg::ST_DRY_WAIT;
            cool_sel_d = 1'b0;
          end
        end
      end
      rcm_pkg::ST_COOL: begin
        if (run_load && restart_q) begin
          ph_load = 1'b1;
          ph_val = 10'(`RCM_TSAVE_TK);
        end
      end
      rcm_pkg::ST_DRY_WAIT: begin
        if (!cool_dem) begin
          state_d = rcm_pkg::ST_DRY_ON;
          ph_load = 1'b1;
          ph_val = 10'(`RCM_DRY_ON_TK);
        end
      end
      rcm_pkg::ST_DRY_ON: begin
        if (ph_done || (run_done && temp_q < eff_sp)) begin
          state_d = rcm_pkg::ST_DRY_OFF;
          ph_load = 1'b1;
          ph_val = 10'(`RCM_DRY_OFF_TK);
        end
      end
      rcm_pkg::ST_DRY_OFF: begin
        if (!comp_q && off_done && temp_q > cool_on_pt) begin
          state_d = rcm_pkg::ST_COOL;
          cool_sel_d = 1'b1;
        end else if (ph_done) begin
          state_d = rcm_pkg::ST_DRY_CYC;
        end
      end
      rcm_pkg::ST_DRY_CYC: begin
        state_d = rcm_pkg::ST_DRY_CYC;
      end
      default: begin
        state_d = rcm_pkg::ST_OFF;
      end
    endcase
    if (cmd.stop) begin
      state_d = rcm_pkg::ST_OFF;
      auto_d = 1'b0;
      ph_load = 1'b1;
      ph_val = 10'h000;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= rcm_pkg::ST_OFF;
      ctrl_q <= '0;
      user_sp_q <= `RCM_SP_RST;
      level_q <= `RCM_LVL_STD;
      auto_q <= 1'b0;
      cool_sel_q <= 1'b1;
      restart_q <= 1'b0;
      comp_q <= 1'b0;
      ofan_q <= 1'b0;
      fan_q <= rcm_pkg::FAN_STOP;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      user_sp_q <= user_sp_d;
      level_q <= level_d;
      auto_q <= auto_d;
      cool_sel_q <= cool_sel_d;
      restart_q <= restart_d;
      comp_q <= comp_d;
      ofan_q <= comp_d;
      fan_q <= fan_d;
      prdata_q <= prdata_d;
      pready_q <= apb_setup;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign comp_on = comp_q;
  assign outdoor_fan_on = ofan_q;
  assign indoor_fan_speed = fan_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_apb_setup;
    psel && !penable && !pready_q;
  endsequence
  sequence s_judge_end;
    state_q == rcm_pkg::ST_JUDGE && ph_done && !cmd.stop;
  endsequence

  AST_APB_ONE_WAIT: assert property (s_apb_setup |=> pready_q ##1 !pready_q)
    else $error("pready not a single cycle after setup");
  AST_SETPT_RANGE: assert property (user_sp_q >= 8'h10 && user_sp_q <= 8'h1E)
    else $error("user setpoint out of range");
  AST_COOL_STOP: assert property (state_q == rcm_pkg::ST_COOL && comp_q && !cool_dem &&
    run_done && !tsave |=> !comp_q)
    else $error("compressor not stopped at setpoint");
  AST_RESTART_DELAY: assert property ($rose(comp_q) |-> $past(off_done))
    else $error("compressor restarted inside delay");
  AST_FORCED_RUN: assert property (comp_q && !run_done && !cmd.stop &&
    state_q != rcm_pkg::ST_OFF |=> comp_q)
    else $error("compressor stopped inside forced run");
  AST_TIME_SAVE: assert property (comp_q && tsave && !cmd.stop |=> comp_q)
    else $error("compressor stopped inside time save");
  AST_DRY_START: assert property (state_q == rcm_pkg::ST_DRY_WAIT && !cool_dem &&
    !cmd.stop |=> state_q == rcm_pkg::ST_DRY_ON)
    else $error("soft dry did not start at setpoint");
  AST_DRY_OFF_HOLD: assert property (state_q == rcm_pkg::ST_DRY_OFF && !ph_done &&
    !cmd.stop && (comp_q || !off_done || temp_q <= cool_on_pt) |=> state_q == rcm_pkg::ST_DRY_OFF)
    else $error("dry off left early");
  AST_DRY_TO_COOL: assert property (state_q == rcm_pkg::ST_DRY_OFF && !comp_q && off_done &&
    temp_q > cool_on_pt && !cmd.stop |=> state_q == rcm_pkg::ST_COOL && cool_sel_q)
    else $error("no fallback to cooling");
  AST_JUDGE_FAN: assert property (state_q == rcm_pkg::ST_JUDGE |=>
    fan_q == rcm_pkg::LOWEST_FAN_SPEED)
    else $error("fan not lowest while judging");
  AST_JUDGE_PICK: assert property (s_judge_end ##0 temp_q >= judge_thr |=>
    state_q == rcm_pkg::ST_COOL ##0 cool_sel_q)
    else $error("judge did not pick cooling");
  AST_AUTO_HOLD: assert property (auto_q && !cmd.stop |=> auto_q && ($stable(cool_sel_q) ||
    state_q == rcm_pkg::ST_COOL || $past(state_q) == rcm_pkg::ST_JUDGE))
    else $error("automatic mode dropped without off");
  AST_AUTO_STD: assert property (auto_q && !strap_q && level_q == 2'h0 |->
    eff_sp == (cool_sel_q ? 8'h19 : 8'h16))
    else $error("wrong automatic standard setpoint");
  AST_LEVEL_BOUND: assert property (level_q != 2'h2 and
    (auto_q && cmd.up && level_q == 2'h1 |=> level_q == 2'h1))
    else $error("level moved beyond one step");
  AST_STRAP_OFFSET: assert property (strap_q && auto_q && level_q == 2'h0 |->
    judge_thr == 8'h19 && eff_sp == (cool_sel_q ? 8'h1B : 8'h18))
    else $error("strap offset missing");
  AST_OFAN_FOLLOW: assert property (outdoor_fan_on == comp_on)
    else $error("outdoor fan not with compressor");
endmodule : rcm_seq

// ---- rcm_defs.svh ----
// Offsets, reset values, temperatures and interval counts for the mode sequencer
`ifndef RCM_DEFS_SVH
`define RCM_DEFS_SVH

`define RCM_CLK_HZ 100000000
`define RCM_TICK_S 1
`define RCM_TICK_CYCLES (`RCM_TICK_S * `RCM_CLK_HZ)
`define RCM_S_PER_MIN 60

`define RCM_RESTART_MIN 3
`define RCM_FORCED_S 60
`define RCM_TSAVE_MIN 7
`define RCM_DRY_ON_MIN 10
`define RCM_DRY_OFF_MIN 6
`define RCM_JUDGE_S 25

`define RCM_RESTART_TK (`RCM_RESTART_MIN * `RCM_S_PER_MIN / `RCM_TICK_S)
`define RCM_FORCED_TK (`RCM_FORCED_S / `RCM_TICK_S)
`define RCM_TSAVE_TK (`RCM_FORCED_TK + `RCM_TSAVE_MIN * `RCM_S_PER_MIN / `RCM_TICK_S)
`define RCM_DRY_ON_TK (`RCM_DRY_ON_MIN * `RCM_S_PER_MIN / `RCM_TICK_S)
`define RCM_DRY_OFF_TK (`RCM_DRY_OFF_MIN * `RCM_S_PER_MIN / `RCM_TICK_S)
`define RCM_JUDGE_TK (`RCM_JUDGE_S / `RCM_TICK_S)

`define RCM_SP_MIN 8'h10
`define RCM_SP_MAX 8'h1E
`define RCM_SP_RST 8'h19
`define RCM_JUDGE_THR 8'h17
`define RCM_AUTO_COOL_SP 8'h19
`define RCM_AUTO_DRY_SP 8'h16
`define RCM_LVL_STEP 8'h02
`define RCM_STRAP_ADD 8'h02
`define RCM_COOL_ON_HYST 8'h01

`define RCM_LVL_STD 2'h0
`define RCM_LVL_UP 2'h1
`define RCM_LVL_DN 2'h3

`define RCM_OFF_CTRL 8'h00
`define RCM_OFF_CMD 8'h04
`define RCM_OFF_SETPT 8'h08
`define RCM_OFF_STATUS 8'h0C
`define RCM_OFF_TEMP 8'h10

`endif

// ---- rcm_pkg.sv ----
// Types shared by the mode sequencer
package rcm_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_JUDGE = 3'b001,
    ST_COOL = 3'b010,
    ST_DRY_WAIT = 3'b100,
    ST_DRY_ON = 3'b101,
    ST_DRY_OFF = 3'b110,
    ST_DRY_CYC = 3'b111
  } rcm_state_e;
  typedef enum logic [1:0] {
    MODE_COOL = 2'b00,
    MODE_DRY = 2'b01,
    MODE_AUTO = 2'b10
  } rcm_mode_e;
  typedef enum logic [1:0] {
    FSEL_AUTO = 2'b00,
    FSEL_LO = 2'b01,
    FSEL_ME = 2'b10,
    FSEL_HI = 2'b11
  } rcm_fsel_e;
  typedef enum logic [2:0] {
    FAN_STOP = 3'b000,
    LOWEST_FAN_SPEED = 3'b001,
    FAN_LO = 3'b010,
    FAN_ME = 3'b011,
    FAN_HI = 3'b100
  } rcm_fan_e;
  typedef struct packed {
    rcm_fsel_e fan_sel;
    rcm_mode_e mode;
  } rcm_ctrl_s;
  typedef struct packed {
    logic down;
    logic up;
    logic stop;
    logic start;
  } rcm_cmd_s;
endpackage : rcm_pkg

// ---- rcm_tick.sv ----
// One-second tick divider from the system clock
`timescale 1ns/1ps
`include "rcm_defs.svh"
module rcm_tick #(
  parameter int unsigned CYCLES = `RCM_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  output logic tick
);
  logic [31:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    cnt_d = cnt_q + 32'h1;
    tick_d = 1'b0;
    if (cnt_q >= 32'(CYCLES - 1)) begin
      cnt_d = 32'h0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule : rcm_tick

// ---- rcm_timer.sv ----
// Loadable down-counter of ticks, done while at zero
`timescale 1ns/1ps
module rcm_timer (
  input wire logic clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic load,
  input wire logic [9:0] load_val,
  output logic done
);
  logic [9:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (tick && cnt_q != 10'h000) begin
      cnt_d = cnt_q - 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == 10'h000);
endmodule : rcm_timer

// ---- rcm_plant_model.sv ----
// Far-side model: intake sensor, offset strap and compressor/fan loads
`timescale 1ns/1ps
module rcm_plant_model (
  input wire logic clk,
  input wire logic [7:0] set_temp,
  input wire logic set_strap,
  input wire logic comp_on,
  input wire logic outdoor_fan_on,
  output logic [7:0] intake_temp,
  output logic mode_offset_strap,
  output logic [31:0] fan_err
);
  logic [7:0] temp_r = 8'h14;
  logic strap_r = 1'b0;
  logic [31:0] err_r = 32'h0;
  // Sensor and strap settle one clock after the room changes, like a real sampler
  always @(posedge clk) begin
    temp_r <= set_temp;
    strap_r <= set_strap;
  end
  always @(posedge clk) begin
    if (outdoor_fan_on !== comp_on) begin
      err_r <= err_r + 32'h1;
    end
  end
  assign intake_temp = temp_r;
  assign mode_offset_strap = strap_r;
  assign fan_err = err_r;
endmodule : rcm_plant_model

// ---- rcm_testbench.sv ----
// Self-checking bench for the mode sequencer
`timescale 1ns/1ps
module testbench;
  localparam int T = 10;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] intake_temp;
  logic [7:0] set_temp = 8'h14;
  logic mode_offset_strap;
  logic set_strap = 1'b0;
  logic comp_on;
  logic outdoor_fan_on;
  logic [2:0] indoor_fan_speed;
  logic [31:0] fan_err;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;
  logic [31:0] rd;
  logic er;
  int cyc;
  logic [7:0] sp_wr [4] = '{8'h0F, 8'h10, 8'h1F, 8'h1E};
  logic [7:0] sp_ex [4] = '{8'h19, 8'h10, 8'h10, 8'h1E};
  logic a_strap [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic [7:0] a_temp [4] = '{8'h17, 8'h16, 8'h18, 8'h19};
  logic a_cool [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0] a_sp [4] = '{8'h19, 8'h16, 8'h18, 8'h1B};
  logic [31:0] l_cmd [6] = '{32'h4, 32'h4, 32'h8, 32'h8, 32'h8, 32'h4};
  logic [7:0] l_sp [6] = '{8'h1B, 8'h1B, 8'h19, 8'h17, 8'h17, 8'h19};
  logic [1:0] l_lv [6] = '{2'h1, 2'h1, 2'h0, 2'h3, 2'h3, 2'h0};

  always #5 clk = ~clk;
  always @(posedge clk) cyc_cnt <= cyc_cnt + 1;

  rcm_seq #(.TICK_CYCLES(T)) DUT (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .intake_temp(intake_temp),
    .mode_offset_strap(mode_offset_strap), .comp_on(comp_on),
    .outdoor_fan_on(outdoor_fan_on), .indoor_fan_speed(indoor_fan_speed)
  );

  rcm_plant_model plant (
    .clk(clk), .set_temp(set_temp), .set_strap(set_strap), .comp_on(comp_on),
    .outdoor_fan_on(outdoor_fan_on), .intake_temp(intake_temp),
    .mode_offset_strap(mode_offset_strap), .fan_err(fan_err)
  );

  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One idle edge before each setup, so back-to-back calls never drive twice at one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd & m, exp);
  endtask : rdm

  // Kind 0: compressor equals v; 1: state equals v; 2: state differs from v
  task automatic wait_for(input int sel, input logic [2:0] v, input int lim, output int c);
    int t0;
    logic hit;
    t0 = cyc_cnt;
    hit = 1'b0;
    while (!hit && cyc_cnt - t0 < lim) begin
      if (sel == 0) begin
        @(posedge clk);
        hit = (comp_on === v[0]);
      end else begin
        apb(1'b0, 8'h0C, 32'h0, rd, er);
        hit = (rd[2:0] === v) ^ (sel == 2);
      end
    end
    c = cyc_cnt - t0;
    chk({31'h0, hit}, 32'h1);
  endtask : wait_for

  task automatic in_rng(input int c, input int lo_s, input int hi_s);
    chk({31'h0, c >= lo_s * T && c <= hi_s * T}, 32'h1);
  endtask : in_rng

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdm(8'h00, 32'hFFFFFFFF, 32'h0);
    rdm(8'h08, 32'hFFFFFFFF, 32'h19);
    rdm(8'h0C, 32'h7, 32'h0);
    chk({27'h0, comp_on, outdoor_fan_on, indoor_fan_speed}, 32'h0);
    apb(1'b0, 8'h14, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, 8'hFC, 32'h5, rd, er);
    chk({31'h0, er}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(8'h08, {24'h0, sp_wr[i]});
      rdm(8'h08, 32'hFF, {24'h0, sp_ex[i]});
    end
    rdm(8'h10, 32'hFF, 32'h14);
    wr(8'h04, 32'h4);
    wr(8'h04, 32'h8);
    rdm(8'h08, 32'hFF, 32'h1D);
    wr(8'h08, 32'h19);
    // Cooling cycle: forced run, restart hold, time save, stop inside the next restart's forced run
    set_temp <= 8'h1E;
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h1);
    wait_for(0, 3'h1, 50, cyc);
    @(posedge clk);
    chk({29'h0, indoor_fan_speed}, {29'h0, rcm_pkg::FAN_ME});
    set_temp <= 8'h14;
    wait_for(0, 3'h0, 70 * T, cyc);
    in_rng(cyc, 58, 62);
    chk({30'h0, outdoor_fan_on, comp_on}, 32'h0);
    set_temp <= 8'h1E;
    wait_for(0, 3'h1, 200 * T, cyc);
    in_rng(cyc, 178, 182);
    set_temp <= 8'h14;
    wait_for(0, 3'h0, 500 * T, cyc);
    in_rng(cyc, 478, 482);
    set_temp <= 8'h1E;
    wait_for(0, 3'h1, 200 * T, cyc);
    for (int j = 1; j < 4; j++) begin
      wr(8'h00, {28'h0, 2'(j), 2'h0});
      repeat (2) @(posedge clk);
      chk({29'h0, indoor_fan_speed}, 32'(j + 1));
    end
    wr(8'h04, 32'h2);
    wait_for(0, 3'h0, 10, cyc);
    rdm(8'h0C, 32'h7, 32'h0);
    // Automatic mode: judge, threshold, standard setpoints, strap, level steps
    for (int i = 0; i < 4; i++) begin
      set_strap <= a_strap[i];
      set_temp <= a_temp[i];
      repeat (4) @(posedge clk);
      wr(8'h00, 32'h2);
      wr(8'h04, 32'h1);
      rdm(8'h0C, 32'h7, 32'h1);
      chk({29'h0, indoor_fan_speed}, {29'h0, rcm_pkg::LOWEST_FAN_SPEED});
      wait_for(2, 3'h1, 40 * T, cyc);
      in_rng(cyc, 23, 26);
      rdm(8'h0C, 32'h1FFF0, {15'h0, a_strap[i], a_sp[i], 2'h0, a_cool[i], 1'b1, 4'h0});
      if (i == 0) begin
        for (int j = 0; j < 6; j++) begin
          wr(8'h04, l_cmd[j]);
          rdm(8'h0C, 32'hFFC0, {16'h0, l_sp[j], l_lv[j], 6'h0});
        end
        set_temp <= 8'h0A;
        repeat (20) @(posedge clk);
        rdm(8'h0C, 32'h30, 32'h30);
      end
      wr(8'h04, 32'h2);
      rdm(8'h0C, 32'h7, 32'h0);
    end
    // Soft dry: let the restart hold from the last stop run out first
    set_strap <= 1'b0;
    set_temp <= 8'h1E;
    repeat (185 * T) @(posedge clk);
    wr(8'h08, 32'h19);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h1);
    rdm(8'h0C, 32'h7, 32'h4);
    set_temp <= 8'h19;
    wait_for(1, 3'h5, 100, cyc);
    wait_for(1, 3'h6, 620 * T, cyc);
    in_rng(cyc, 598, 602);
    repeat (2) @(posedge clk);
    chk({31'h0, comp_on}, 32'h0);
    set_temp <= 8'h1B;
    wait_for(1, 3'h2, 200 * T, cyc);
    in_rng(cyc, 177, 182);
    wait_for(0, 3'h1, 100, cyc);
    wr(8'h04, 32'h2);
    wait_for(0, 3'h0, 20, cyc);
    chk(fan_err, 32'h0);
    complete_run();
  end
endmodule : testbench
